// [sim/tfc_filling_monitor.sv]
`timescale 1ns/1ps
module tfc_filling_monitor (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         blocking_pin,
  input wire logic [119:0] relay_busy_ext,
  input wire logic [119:0] relay_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // relay plan: bit 0 dribble, bit 1 bulk, bit 2 active
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h44 |=> pslverr)
    else $error("unmapped not refused");
  a_err_mapped: assert property (psel && !penable && paddr <= 8'h44 && paddr[1:0] == 2'b00
    |=> !pslverr) else $error("mapped refused");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");
  a_relay_reset: assert property ($rose(presetn) |-> relay_out == '0)
    else $error("relay on after reset");
  a_busy_free: assert property ((relay_out & relay_busy_ext) == '0)
    else $error("busy relay driven");
  a_block_feed: assert property (blocking_pin [*5] |-> relay_out[1:0] == 2'b00)
    else $error("feed on while blocked");
  a_bulk_drib: assert property (relay_out[1] |-> relay_out[0])
    else $error("bulk on without dribble");
  a_drib_act: assert property (relay_out[0] |-> relay_out[2])
    else $error("feed without active");
endmodule // tfc_filling_monitor

bind tfc_filling_controller tfc_filling_monitor mon_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .blocking_pin(blocking_pin), .relay_busy_ext(relay_busy_ext),
  .relay_out(relay_out));

// [sim/tfc_scale_model.sv]
`timescale 1ns/1ps
module tfc_scale_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic signed [23:0] goal,
  output tfc_pkg::tfc_weight_type scale_out
);
  import tfc_pkg::*;
  // moves one count a cycle so every cut point is crossed, never jumped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scale_out <= '0;
    end else begin
      scale_out.stable <= (scale_out.weight == goal);
      if (scale_out.weight < goal) begin
        scale_out.weight <= scale_out.weight + 24'sh00_0001;
      end else if (scale_out.weight > goal) begin
        scale_out.weight <= scale_out.weight - 24'sh00_0001;
      end
    end
  end
endmodule // tfc_scale_model

// [sim/truck_filling_controller_test.sv]
`timescale 1ns/1ps
`include "tfc_consts.svh"
module truck_filling_controller_test;
  import tfc_pkg::*;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               blocking_pin = 1'b0;
  logic [119:0]       relay_busy_ext = '0;
  logic [119:0]       relay_out;
  logic signed [23:0] goal = 24'h0;
  tfc_weight_type     scale_in;
  logic [31:0]        rd;
  logic               rerr;
  int                 errors = 0;
  int                 n_checks = 0;

  always #5 pclk = ~pclk;

  tfc_filling_controller #(.SEC_CYCLES(20), .MS_CYCLES(4)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scale_in(scale_in),
    .blocking_pin(blocking_pin), .relay_busy_ext(relay_busy_ext), .relay_out(relay_out));
  tfc_scale_model scale_u (.pclk(pclk), .presetn(presetn), .goal(goal), .scale_out(scale_in));

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic tmo;
    errors++;
    $display("wrong value at %0t: wait ran out", $time);
    end_of_test();
  endtask

  // idle edge first; answer sampled mid-cycle, released after its edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50 && pready !== 1'b1; k++) @(negedge pclk);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    rerr = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic cmd(input int b);
    apb(1'b1, `TFC_REG_CMD, 32'h1 << b);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string what);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e, what);
  endtask

  task automatic wait_st(input logic [2:0] s);
    apb(1'b0, `TFC_REG_STATUS, 32'h0);
    for (int k = 0; rd[2:0] !== s; k++) begin
      if (k > 3000) tmo();
      apb(1'b0, `TFC_REG_STATUS, 32'h0);
    end
  endtask

  task automatic wait_rly(input int b, input logic v);
    for (int k = 0; relay_out[b] !== v; k++) begin
      if (k > 3000) tmo();
      @(posedge pclk);
    end
  endtask

  task automatic wait_w(input logic signed [23:0] g);
    goal <= g;
    for (int k = 0; scale_in.weight !== g; k++) begin
      if (k > 3000) tmo();
      @(posedge pclk);
    end
  endtask

  task automatic fill(input logic signed [23:0] g);
    wait_w(24'h0);
    cmd(`TFC_CMD_START);
    goal <= g;
  endtask

  // relay drops within a few counts of the cut
  task automatic cut_at(input int b, input int cut);
    wait_rly(b, 1'b1);
    wait_rly(b, 1'b0);
    chk({31'h0, scale_in.weight >= cut && scale_in.weight <= cut + 4}, 32'h1, "cut");
  endtask

  task automatic t_reset;
    for (int a = 16; a <= 48; a += 4) begin
      rdc(8'(a), 32'hFFFF_FFFF, 32'h0, "reset value");
    end
    apb(1'b0, 8'h48, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped");
    $display("reset test done");
  endtask

  task automatic t_assign;
    wr(`TFC_REG_CTRL, 32'h1);
    wr(`TFC_REG_ASSIGN, 32'h111);
    cmd(`TFC_CMD_START);
    rdc(`TFC_REG_STATUS, 32'h27, 32'h20, "start refused");
    wr(`TFC_REG_ASSIGN, 32'h120);
    wr(`TFC_REG_ASSIGN, 32'h135);
    wr(`TFC_REG_ASSIGN, 32'h113);
    rdc(`TFC_REG_STATUS, 32'h10, 32'h10, "dup relay");
    cmd(`TFC_CMD_CLEAR);
    relay_busy_ext <= 120'h100;
    wr(`TFC_REG_ASSIGN, 32'h214);
    rdc(`TFC_REG_STATUS, 32'h10, 32'h10, "busy relay");
    cmd(`TFC_CMD_CLEAR);
    $display("assign test done");
  endtask

  task automatic t_fill;
    wr(`TFC_REG_PRESET, 32'h3E8);
    wr(`TFC_REG_ENTERED, 32'h1F4);
    wr(`TFC_REG_INFLIGHT, 32'h14);
    wr(`TFC_REG_BAND, 32'h64);
    wr(`TFC_REG_ADAPT, 32'h32);
    wr(`TFC_REG_SETTLE, 32'h2);
    fill(24'h3DE);
    cut_at(1, 880);
    chk({31'h0, relay_out[0]}, 32'h1, "dribble kept");
    cut_at(0, 980);
    wait_st(3'h6);
    rdc(`TFC_REG_INFLIGHT, 32'hFFFF_FFFF, 32'h19, "adapted");
    wr(`TFC_REG_CLAMP, 32'h3);
    fill(24'h3FC);
    wait_st(3'h6);
    rdc(`TFC_REG_INFLIGHT, 32'hFFFF_FFFF, 32'h16, "clamped");
    wr(`TFC_REG_ADAPT, 32'h0);
    fill(24'h3F2);
    wait_st(3'h6);
    rdc(`TFC_REG_INFLIGHT, 32'hFFFF_FFFF, 32'h16, "no adapt");
    $display("fill test done");
  endtask

  task automatic t_tol;
    wr(`TFC_REG_TOL_UP, 32'hA);
    wr(`TFC_REG_TOL_LO, 32'hA);
    fill(24'h3FC);
    wait_st(3'h5);
    chk({31'h0, rd[6]}, 32'h1, "over");
    wait_w(24'h3F7);
    cmd(`TFC_CMD_ACCEPT);
    wait_st(3'h6);
    rdc(`TFC_REG_SECOND, 32'hFFFF_FFFF, 32'h3F7, "accepted");
    fill(24'h3D9);
    wait_st(3'h5);
    cmd(`TFC_CMD_REJECT);
    wait_st(3'h0);
    wr(`TFC_REG_CTRL, 32'h3);
    wr(`TFC_REG_TOL_UP, 32'h1);
    wr(`TFC_REG_TOL_LO, 32'h2);
    fill(24'h3D9);
    wait_st(3'h6);
    $display("tolerance test done");
  endtask

  task automatic t_lom;
    wr(`TFC_REG_LOM_TIME, 32'h1);
    fill(24'h0);
    wait_st(3'h2);
    chk({31'h0, rd[7]}, 32'h1, "lack flag");
    cmd(`TFC_CMD_RESUME);
    rdc(`TFC_REG_STATUS, 32'h7, 32'h1, "resumed");
    wait_st(3'h2);
    cmd(`TFC_CMD_CANCEL);
    rdc(`TFC_REG_STATUS, 32'h7, 32'h0, "cancelled");
    wr(`TFC_REG_MIN_RISE, 32'h1);
    wr(`TFC_REG_MIN_RISE, 32'h7);
    rdc(`TFC_REG_MIN_RISE, 32'hFFFF_FFFF, 32'h1, "rise setting");
    fill(24'h3);
    wait_st(3'h2);
    cmd(`TFC_CMD_END);
    wait_st(3'h6);
    rdc(`TFC_REG_SECOND, 32'hFFFF_FFFF, 32'h3, "ended");
    wr(`TFC_REG_LOM_TIME, 32'h0);
    $display("material test done");
  endtask

  task automatic t_block;
    fill(24'h1F4);
    wait_rly(0, 1'b1);
    blocking_pin <= 1'b1;
    wait_rly(0, 1'b0);
    rdc(`TFC_REG_STATUS, 32'h100, 32'h100, "blocked");
    blocking_pin <= 1'b0;
    wait_rly(0, 1'b1);
    cmd(`TFC_CMD_CANCEL);
    cmd(`TFC_CMD_RLY_RESET);
    cmd(`TFC_CMD_START);
    rdc(`TFC_REG_STATUS, 32'h27, 32'h20, "no relays");
    chk({31'h0, relay_out === '0}, 32'h1, "relays idle");
    $display("block test done");
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_assign();
    t_fill();
    t_tol();
    t_lom();
    t_block();
    end_of_test();
  end
endmodule // truck_filling_controller_test

// [verilog/tfc_consts.svh]
`ifndef TFC_CONSTS_SVH
`define TFC_CONSTS_SVH

// register byte offsets
`define TFC_REG_CTRL     8'h00
`define TFC_REG_CMD      8'h04
`define TFC_REG_PRESET   8'h08
`define TFC_REG_ENTERED  8'h0C
`define TFC_REG_INFLIGHT 8'h10
`define TFC_REG_ADAPT    8'h14
`define TFC_REG_CLAMP    8'h18
`define TFC_REG_BAND     8'h1C
`define TFC_REG_TOL_UP   8'h20
`define TFC_REG_TOL_LO   8'h24
`define TFC_REG_LOM_TIME 8'h28
`define TFC_REG_MIN_RISE 8'h2C
`define TFC_REG_SETTLE   8'h30
`define TFC_REG_DIV      8'h34
`define TFC_REG_ASSIGN   8'h38
`define TFC_REG_STATUS   8'h3C
`define TFC_REG_SECOND   8'h40
`define TFC_REG_LIVE     8'h44

// control and command bits
`define TFC_CTRL_TWO_SPEED 0
`define TFC_CTRL_TOL_PCT   1
`define TFC_CTRL_PROMPT_HI 3
`define TFC_CTRL_PROMPT_LO 2
`define TFC_PROMPT_NONE    2'h0
`define TFC_CMD_START      0
`define TFC_CMD_CANCEL     1
`define TFC_CMD_ACCEPT     2
`define TFC_CMD_REJECT     3
`define TFC_CMD_RESUME     4
`define TFC_CMD_END        5
`define TFC_CMD_RLY_RESET  6
`define TFC_CMD_CLEAR      7

// relay functions
`define TFC_FN_COUNT   7
`define TFC_FN_BULK    0
`define TFC_FN_DRIBBLE 1
`define TFC_FN_ERROR   2
`define TFC_FN_TOL     3
`define TFC_FN_LOM     4
`define TFC_FN_ACTIVE  5
`define TFC_FN_PAUSE   6
`define TFC_MOD_NONE   4'h0
`define TFC_RELAY_MAX  8
`define TFC_RELAY_BITS 120

// reset values, last rise setting and percent divisor
`define TFC_RST_ZERO   32'h0
`define TFC_RST_DIV    32'h1
`define TFC_RISE_SETTLED 3'h0
`define TFC_RISE_LAST  3'h6
`define TFC_PCT_DIV    100

// timing
`define TFC_SEC_CYCLES  100000000
`define TFC_MS_CYCLES   100000

`endif

// [verilog/tfc_filling_controller.sv]
// How it works
// [RL1] no-prompt policy uses preset target, else entered
// [RL2] dribble off at target minus free-fall
// [RL3] offset adapts by error times percent/100
// [RL4] zero percent keeps offset unchanged
// [RL5] correction clamped; zero clamp means unlimited
// [RL6] offset, percent, clamp reset to zero
// [RL7] two-speed bulk cut subtracts dribble band too
// [RL8] over upper tolerance flags error relay
// [RL9] under lower tolerance flags error relay
// [RL10] both tolerances zero skips the check
// [RL11] operator accept captures live second weight
// [RL12] detection window in seconds; zero disables
// [RL13] minimum rise: settled or division count
// [RL14] settled mode: stable whole window errors
// [RL15] division mode: too little rise errors
// [RL16] after material error: cancel, resume or end
// [RL17] settle delay after stability, restarts on motion
// [RL18] relay is module 1-15, relay 1-8
// [RL19] status relays follow error and fill states
// [RL20] start refused without required feed relays
// [RL21] reject assignment of relay already used
// [RL22] unassigned drives nothing; reset clears assignments
// [RL23] two-speed: both feeds on below bulk cut
// [RL24] blocking input stops feeds and checks
// [RL25] signed wide arithmetic for cuts, corrections
`timescale 1ns/1ps
`include "tfc_consts.svh"

module tfc_filling_controller #(
  parameter int unsigned SEC_CYCLES = `TFC_SEC_CYCLES,
  parameter int unsigned MS_CYCLES  = `TFC_MS_CYCLES
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  tfc_pkg::tfc_weight_type          scale_in,
  input  wire logic                        blocking_pin,
  input  wire logic [`TFC_RELAY_BITS-1:0]  relay_busy_ext,
  output logic [`TFC_RELAY_BITS-1:0]       relay_out
);
  import tfc_pkg::*;

  tfc_state_type         state;
  tfc_assign_type        asg [`TFC_FN_COUNT];
  logic [31:0]           ctrl;
  logic signed [31:0]    preset_w, entered_w, inflight, clamp, band;
  logic signed [31:0]    tol_up, tol_lo, div_size, second_w;
  logic [7:0]            adapt_pct;
  logic [15:0]           lom_time, settle_ms, lom_sec, settle_cnt;
  logic [2:0]            min_rise, asg_sel;
  logic                  blk_meta, blk;
  logic [31:0]           sec_div, ms_div;
  logic                  sec_tick, ms_tick;
  logic                  lom_hit, second_valid;
  logic                  assign_err, start_err, tol_err, lom_err;
  logic signed [31:0]    lom_ref;

  function automatic logic signed [31:0] tol_limit(input logic signed [31:0] tol,
                                                   input logic signed [31:0] tgt,
                                                   input logic               pct);
    logic signed [63:0] p;
    p = 64'(tol) * 64'(tgt);
    tol_limit = pct ? 32'(p / `TFC_PCT_DIV) : tol;
  endfunction

  function automatic logic signed [31:0] correction(input logic signed [31:0] diff,
                                                    input logic [7:0]         pct,
                                                    input logic signed [31:0] lim);
    logic signed [47:0] q;
    q = (48'(diff) * $signed({40'h0, pct})) / `TFC_PCT_DIV; // RL3 RL25
    if (lim != 0 && q > 48'(lim)) begin
      q = 48'(lim); // RL5
    end
    if (lim != 0 && q < -48'(lim)) begin
      q = -48'(lim); // RL5
    end
    correction = 32'(q);
  endfunction

  function automatic int rise_divs(input logic [2:0] sel);
    case (sel)
      3'h1:    rise_divs = 5;
      3'h2:    rise_divs = 10;
      3'h3:    rise_divs = 20;
      3'h4:    rise_divs = 50;
      3'h5:    rise_divs = 100;
      3'h6:    rise_divs = 200;
      default: rise_divs = 0;
    endcase
  endfunction

  function automatic int relay_index(input tfc_assign_type a);
    relay_index = (int'(a.module_no) - 1) * `TFC_RELAY_MAX + int'(a.relay_no) - 1;
  endfunction

  // bus decode
  logic        wr_en, rd_ok;
  logic [7:0]  cmd;
  logic [31:0] rd_data;
  assign wr_en = psel && penable && pready && pwrite;
  assign cmd   = (wr_en && paddr == `TFC_REG_CMD) ? pwdata[7:0] : 8'h00;

  // arithmetic
  logic signed [31:0] live, target, dribble_cut, bulk_cut, up_lim, lo_lim, rise_w;
  logic               two_speed, check_on, out_tol, fill_run, start_ok;
  assign live        = 32'(scale_in.weight); // RL25
  assign two_speed   = ctrl[`TFC_CTRL_TWO_SPEED];
  assign target      = (ctrl[`TFC_CTRL_PROMPT_HI:`TFC_CTRL_PROMPT_LO] == `TFC_PROMPT_NONE) ?
                       preset_w : entered_w; // RL1
  assign dribble_cut = target - inflight; // RL2
  assign bulk_cut    = dribble_cut - band; // RL7
  assign up_lim      = tol_limit(tol_up, target, ctrl[`TFC_CTRL_TOL_PCT]); // RL8
  assign lo_lim      = tol_limit(tol_lo, target, ctrl[`TFC_CTRL_TOL_PCT]); // RL9
  assign check_on    = (tol_up != 0) || (tol_lo != 0); // RL10
  assign out_tol     = check_on && ((live - target > up_lim) || (target - live > lo_lim)); // RL8 RL9
  assign rise_w      = 32'(rise_divs(min_rise) * div_size);
  assign fill_run    = (state == ST_FILL) && !blk; // RL24
  assign start_ok    = (asg[`TFC_FN_DRIBBLE].module_no != `TFC_MOD_NONE) &&
                       (!two_speed || asg[`TFC_FN_BULK].module_no != `TFC_MOD_NONE); // RL20

  // relay assignment check
  tfc_assign_type new_asg;
  logic           asg_ok;
  always_comb begin
    new_asg = tfc_assign_type'(pwdata[11:4]);
    asg_ok  = (pwdata[2:0] < 3'(`TFC_FN_COUNT)) &&
              ((new_asg.module_no == `TFC_MOD_NONE) ||
               (new_asg.relay_no >= 4'h1 && new_asg.relay_no <= 4'(`TFC_RELAY_MAX))); // RL18
    if (asg_ok && new_asg.module_no != `TFC_MOD_NONE) begin
      if (relay_busy_ext[relay_index(new_asg)]) begin
        asg_ok = 1'b0; // RL21
      end
      for (int j = 0; j < `TFC_FN_COUNT; j++) begin
        if (3'(j) != pwdata[2:0] && asg[j] == new_asg) begin
          asg_ok = 1'b0; // RL21
        end
      end
    end
  end

  // blocking pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_meta <= 1'b0;
      blk      <= 1'b0;
    end else begin
      blk_meta <= blocking_pin;
      blk      <= blk_meta;
    end
  end

  // second and millisecond enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_div  <= '0;
      ms_div   <= '0;
      sec_tick <= 1'b0;
      ms_tick  <= 1'b0;
    end else begin
      sec_tick <= (sec_div == 32'(SEC_CYCLES - 1));
      ms_tick  <= (ms_div == 32'(MS_CYCLES - 1));
      sec_div  <= (sec_div == 32'(SEC_CYCLES - 1)) ? '0 : sec_div + 32'h1;
      ms_div   <= (ms_div == 32'(MS_CYCLES - 1)) ? '0 : ms_div + 32'h1;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= `TFC_RST_ZERO;
      preset_w  <= `TFC_RST_ZERO;
      entered_w <= `TFC_RST_ZERO;
      adapt_pct <= '0; // RL6
      clamp     <= `TFC_RST_ZERO; // RL6
      band      <= `TFC_RST_ZERO; // RL7
      tol_up    <= `TFC_RST_ZERO; // RL10
      tol_lo    <= `TFC_RST_ZERO; // RL10
      lom_time  <= '0; // RL12
      min_rise  <= `TFC_RISE_SETTLED; // RL13
      settle_ms <= '0; // RL17
      div_size  <= `TFC_RST_DIV;
    end else if (wr_en) begin
      case (paddr)
        `TFC_REG_CTRL:     ctrl      <= {28'h0, pwdata[3:0]};
        `TFC_REG_PRESET:   preset_w  <= pwdata;
        `TFC_REG_ENTERED:  entered_w <= pwdata;
        `TFC_REG_ADAPT:    adapt_pct <= pwdata[7:0];
        `TFC_REG_CLAMP:    clamp     <= pwdata;
        `TFC_REG_BAND:     band      <= pwdata;
        `TFC_REG_TOL_UP:   tol_up    <= pwdata;
        `TFC_REG_TOL_LO:   tol_lo    <= pwdata;
        `TFC_REG_LOM_TIME: lom_time  <= pwdata[15:0];
        `TFC_REG_MIN_RISE: begin
          if (pwdata[2:0] <= `TFC_RISE_LAST && pwdata[31:3] == '0) begin
            min_rise <= pwdata[2:0]; // RL13
          end
        end
        `TFC_REG_SETTLE:   settle_ms <= pwdata[15:0];
        `TFC_REG_DIV:      div_size  <= pwdata;
        default: ;
      endcase
    end
  end

  // free-fall offset: adaptation beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inflight <= `TFC_RST_ZERO; // RL6
    end else if (state == ST_CHECK && adapt_pct != 8'h00) begin
      inflight <= inflight + correction(target - live, adapt_pct, clamp); // RL3 RL4
    end else if (wr_en && paddr == `TFC_REG_INFLIGHT) begin
      inflight <= pwdata;
    end
  end

  // relay assignments
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int f = 0; f < `TFC_FN_COUNT; f++) begin
        asg[f] <= '0;
      end
      asg_sel <= '0;
    end else if (cmd[`TFC_CMD_RLY_RESET]) begin
      for (int f = 0; f < `TFC_FN_COUNT; f++) begin
        asg[f] <= '0; // RL22
      end
    end else if (wr_en && paddr == `TFC_REG_ASSIGN) begin
      asg_sel <= pwdata[2:0];
      if (asg_ok) begin
        asg[pwdata[2:0]] <= new_asg; // RL18 RL21
      end
    end
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE, ST_DONE: begin
          if (cmd[`TFC_CMD_START] && start_ok) begin
            state <= ST_FILL; // RL20
          end
        end
        ST_FILL: begin
          if (cmd[`TFC_CMD_CANCEL]) begin
            state <= ST_IDLE;
          end else if (fill_run && live >= dribble_cut) begin
            state <= ST_SETTLE; // RL2
          end else if (fill_run && lom_hit) begin
            state <= ST_LOM; // RL14 RL15
          end
        end
        ST_LOM: begin
          if (cmd[`TFC_CMD_CANCEL]) begin
            state <= ST_IDLE; // RL16
          end else if (cmd[`TFC_CMD_RESUME]) begin
            state <= ST_FILL; // RL16
          end else if (cmd[`TFC_CMD_END]) begin
            state <= ST_DONE; // RL16
          end
        end
        ST_SETTLE: begin
          if (cmd[`TFC_CMD_CANCEL]) begin
            state <= ST_IDLE;
          end else if (scale_in.stable && settle_cnt >= settle_ms) begin
            state <= ST_CHECK; // RL17
          end
        end
        ST_CHECK: state <= out_tol ? ST_TOL : ST_DONE; // RL8 RL9
        ST_TOL: begin
          if (cmd[`TFC_CMD_ACCEPT]) begin
            state <= ST_DONE; // RL11
          end else if (cmd[`TFC_CMD_REJECT] || cmd[`TFC_CMD_CANCEL]) begin
            state <= ST_IDLE; // RL11
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // settle delay counts milliseconds of unbroken stability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= '0;
    end else if (state != ST_SETTLE || !scale_in.stable) begin
      settle_cnt <= '0; // RL17
    end else if (ms_tick && settle_cnt < settle_ms) begin
      settle_cnt <= settle_cnt + 16'h1;
    end
  end

  // lack of material watch; frozen while blocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lom_sec <= '0;
      lom_ref <= `TFC_RST_ZERO;
      lom_hit <= 1'b0;
    end else if (state != ST_FILL || lom_time == 16'h0000) begin
      lom_sec <= '0; // RL12
      lom_ref <= live;
      lom_hit <= 1'b0;
    end else if (fill_run) begin
      if (min_rise == `TFC_RISE_SETTLED) begin
        if (!scale_in.stable) begin
          lom_sec <= '0; // RL14
        end else if (sec_tick) begin
          lom_sec <= lom_sec + 16'h1;
          lom_hit <= (lom_sec + 16'h1 >= lom_time); // RL14
        end
      end else if (sec_tick) begin
        if (lom_sec + 16'h1 >= lom_time) begin
          lom_sec <= '0;
          lom_ref <= live;
          lom_hit <= (live - lom_ref <= rise_w); // RL15
        end else begin
          lom_sec <= lom_sec + 16'h1;
        end
      end
    end
  end

  // second weighing capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_w     <= `TFC_RST_ZERO;
      second_valid <= 1'b0;
    end else if ((state == ST_CHECK && !out_tol) ||
                 (state == ST_TOL && cmd[`TFC_CMD_ACCEPT]) || // RL11
                 (state == ST_LOM && !cmd[`TFC_CMD_CANCEL] && !cmd[`TFC_CMD_RESUME] &&
                  cmd[`TFC_CMD_END])) begin // RL16
      second_w     <= live;
      second_valid <= 1'b1;
    end else if (cmd[`TFC_CMD_START] && start_ok && (state == ST_IDLE || state == ST_DONE)) begin
      second_valid <= 1'b0;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  logic start_now;
  assign start_now = cmd[`TFC_CMD_START] && (state == ST_IDLE || state == ST_DONE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      assign_err <= 1'b0;
      start_err  <= 1'b0;
      tol_err    <= 1'b0;
      lom_err    <= 1'b0;
    end else begin
      if (wr_en && paddr == `TFC_REG_ASSIGN && !asg_ok && !cmd[`TFC_CMD_RLY_RESET]) begin
        assign_err <= 1'b1; // RL21
      end else if (cmd[`TFC_CMD_CLEAR]) begin
        assign_err <= 1'b0;
      end
      if (start_now && !start_ok) begin
        start_err <= 1'b1; // RL20
      end else if (cmd[`TFC_CMD_CLEAR] || start_now) begin
        start_err <= 1'b0;
      end
      if (state == ST_CHECK && out_tol) begin
        tol_err <= 1'b1; // RL8 RL9
      end else if (cmd[`TFC_CMD_CLEAR] || (start_now && start_ok)) begin
        tol_err <= 1'b0;
      end
      if (fill_run && lom_hit && !cmd[`TFC_CMD_CANCEL] && live < dribble_cut) begin
        lom_err <= 1'b1; // RL14 RL15
      end else if (cmd[`TFC_CMD_CLEAR] || (start_now && start_ok)) begin
        lom_err <= 1'b0;
      end
    end
  end

  // relay drive: only assigned functions reach a relay
  logic [`TFC_FN_COUNT-1:0]   fn_on;
  logic [`TFC_RELAY_BITS-1:0] next_relay;
  always_comb begin
    fn_on                  = '0;
    fn_on[`TFC_FN_BULK]    = fill_run && two_speed && live < bulk_cut; // RL7 RL23 RL24
    fn_on[`TFC_FN_DRIBBLE] = fill_run && live < dribble_cut; // RL2 RL23 RL24
    fn_on[`TFC_FN_ERROR]   = tol_err || lom_err; // RL19
    fn_on[`TFC_FN_TOL]     = tol_err; // RL19
    fn_on[`TFC_FN_LOM]     = lom_err; // RL19
    fn_on[`TFC_FN_ACTIVE]  = state != ST_IDLE && state != ST_DONE; // RL19
    fn_on[`TFC_FN_PAUSE]   = (state == ST_FILL && blk) || state == ST_LOM; // RL19 RL24
    next_relay = '0;
    for (int f = 0; f < `TFC_FN_COUNT; f++) begin
      if (asg[f].module_no != `TFC_MOD_NONE && fn_on[f]) begin
        next_relay[relay_index(asg[f])] = 1'b1; // RL22
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_out <= '0;
    end else begin
      relay_out <= next_relay;
    end
  end

  // register read mux
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = '0;
    case (paddr)
      `TFC_REG_CTRL:     rd_data = ctrl;
      `TFC_REG_CMD:      rd_data = '0;
      `TFC_REG_PRESET:   rd_data = preset_w;
      `TFC_REG_ENTERED:  rd_data = entered_w;
      `TFC_REG_INFLIGHT: rd_data = inflight;
      `TFC_REG_ADAPT:    rd_data = {24'h0, adapt_pct};
      `TFC_REG_CLAMP:    rd_data = clamp;
      `TFC_REG_BAND:     rd_data = band;
      `TFC_REG_TOL_UP:   rd_data = tol_up;
      `TFC_REG_TOL_LO:   rd_data = tol_lo;
      `TFC_REG_LOM_TIME: rd_data = {16'h0, lom_time};
      `TFC_REG_MIN_RISE: rd_data = {29'h0, min_rise};
      `TFC_REG_SETTLE:   rd_data = {16'h0, settle_ms};
      `TFC_REG_DIV:      rd_data = div_size;
      `TFC_REG_ASSIGN:   rd_data = {20'h0, asg[asg_sel], 1'b0, asg_sel};
      `TFC_REG_STATUS:   rd_data = {22'h0, second_valid, blk, lom_err, tol_err,
                                    start_err, assign_err, 1'b0, state};
      `TFC_REG_SECOND:   rd_data = second_w;
      `TFC_REG_LIVE:     rd_data = live;
      default:           rd_ok = 1'b0;
    endcase
  end

  // apb slave: answers in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= !rd_ok;
      prdata  <= pwrite ? '0 : rd_data;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // tfc_filling_controller

// [verilog/tfc_pkg.sv]
package tfc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FILL, ST_LOM, ST_SETTLE, ST_CHECK, ST_TOL, ST_DONE
  } tfc_state_type;

  typedef struct packed {
    logic [3:0] module_no;
    logic [3:0] relay_no;
  } tfc_assign_type;

  typedef struct packed {
    logic signed [23:0] weight;
    logic               stable;
  } tfc_weight_type;
endpackage
